// *** rtl/mod_cfg_irq.sv ***
// Modulator configuration word, interrupt control and FIFO error flags.
//
// What this block does
// - A six-bit field sets the value at which the slot counter wraps to 0.
// - The ready-sync enable bit turns internal ready sync pulses on or off.
// - The rate bit selects single rate input at 1 and double rate at 0.
// - Each of four combiner-off bits disables one combiner and its clocks.
// - The test bit forces the interrupt without any real event.
// - The global enable gates all interrupt signalling.
// - Five sources each have their own interrupt enable bit.
// - Live status shows power period done, output check and channel limit.
// - Held copies of those three catch each event and clear on read.
// - Underflow group bits 8 to 15 each cover sixteen channels.
// - Overflow group bits 0 to 7 each cover sixteen channels.
// - FIFO n, for n from 1 to 48, has its overflow flag at bit (n-1)%16 of word 0x583+(n-1)/16.
// - A FIFO overflow flag stays set until its word is read, then clears.
// - The flag word for FIFOs 33 to 48 resets to all zeros.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module mod_cfg_irq
  import mod_cfg_pkg::*;
#(
  parameter int CHANNELS = mod_cfg_pkg::NUM_CHAN
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [mod_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mod_cfg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mod_cfg_pkg::DATA_W-1:0] reg_rdata,
  // Event and status inputs from the datapath
  input wire logic power_period_done,
  input wire logic output_check_active,
  input wire logic chan_limit_hit,
  input wire logic [CHANNELS-1:0] fifo_overflow_evt,
  input wire logic [CHANNELS-1:0] fifo_underflow_evt,
  // Controls to the datapath
  output logic [5:0] slot_count,
  output logic ready_sync,
  output logic single_rate_select,
  output logic [3:0] combiner_clk_en,
  // Interrupt
  output logic irq
);
  import mod_cfg_pkg::*;

  function automatic logic [NUM_GROUPS-1:0] group_or(
    input logic [CHANNELS-1:0] ev
  );
    logic [NUM_GROUPS-1:0] g;
    g = '0;
    for (int i = 0; i < NUM_GROUPS; i++)
    begin
      g[i] = |ev[i*GROUP_SIZE +: GROUP_SIZE];
    end
    return g;
  endfunction

  reg_req_s req;
  modulator_config_s cfg_reg, cfg_next;
  irq_enable_s en_reg, en_next;
  logic [2:0] live_reg;
  logic [2:0] held_reg, held_next;
  logic [NUM_GROUPS-1:0] ovf_group_reg, ovf_group_next;
  logic [NUM_GROUPS-1:0] udf_group_reg, udf_group_next;
  logic [NUM_FLAGGED-1:0] fifo_flag_reg, fifo_flag_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [5:0] slot_reg, slot_next;
  logic sync_reg, sync_next;
  logic irq_reg, irq_next;
  logic [3:0] clk_en_reg, clk_en_next;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  wire hit_cfg = req.addr == MODULATOR_CONFIG_OFS;
  wire hit_irq = req.addr == IRQ_ENABLE_AND_STATUS_OFS;
  wire hit_sum = req.addr == FIFO_ERROR_SUMMARY_OFS;
  wire hit_f0 = req.addr == OVERFLOW_FLAGS_FIFO_1_16_OFS;
  wire hit_f1 = req.addr == OVERFLOW_FLAGS_FIFO_17_32_OFS;
  wire hit_f2 = req.addr == OVERFLOW_FLAGS_FIFO_33_48_OFS;

  // Events are rising edges of the live levels, so a level that stays high
  // does not re-arm a held bit that software has just cleared.
  wire [2:0] live_now = {power_period_done, output_check_active,
                         chan_limit_hit};
  wire [2:0] live_rise = live_now & ~live_reg;
  wire clr_held = req.rd & hit_irq;
  // The set term is applied after the clear so a coincident event survives.
  assign held_next = (held_reg & ~{3{clr_held}}) | live_rise;

  wire [NUM_GROUPS-1:0] ovf_groups = group_or(fifo_overflow_evt);
  wire [NUM_GROUPS-1:0] udf_groups = group_or(fifo_underflow_evt);
  wire clr_sum = req.rd & hit_sum;
  assign ovf_group_next = (ovf_group_reg & ~{NUM_GROUPS{clr_sum}})
                          | ovf_groups;
  assign udf_group_next = (udf_group_reg & ~{NUM_GROUPS{clr_sum}})
                          | udf_groups;

  wire [NUM_FLAGGED-1:0] flag_clr = {{GROUP_SIZE{req.rd & hit_f2}},
                                     {GROUP_SIZE{req.rd & hit_f1}},
                                     {GROUP_SIZE{req.rd & hit_f0}}};
  assign fifo_flag_next = (fifo_flag_reg & ~flag_clr)
                          | fifo_overflow_evt[NUM_FLAGGED-1:0];

  wire ovf_any = |ovf_group_reg;
  wire udf_any = |udf_group_reg;
  irq_status_s status;
  assign status = '{
    power_period_done: live_reg[2],
    output_check_active: live_reg[1],
    chan_limit_hit: live_reg[0],
    power_period_done_held: held_reg[2],
    output_check_held: held_reg[1],
    overflow_held: ovf_any,
    underflow_held: udf_any,
    chan_limit_held: held_reg[0]
  };

  assign cfg_next = (req.wr & hit_cfg) ? modulator_config_s'(req.wdata)
                                       : cfg_reg;
  assign en_next = (req.wr & hit_irq)
                   ? irq_enable_s'(req.wdata[15:IRQ_EN_LSB]) : en_reg;

  wire [15:0] rd_irq = {en_reg, 2'b00, status};
  wire [15:0] rd_sum = {udf_group_reg, ovf_group_reg};
  assign rdata_next = !req.rd ? 16'h0000
                    : hit_cfg ? 16'(cfg_reg)
                    : hit_irq ? rd_irq
                    : hit_sum ? rd_sum
                    : hit_f0 ? fifo_flag_reg[15:0]
                    : hit_f1 ? fifo_flag_reg[31:16]
                    : hit_f2 ? fifo_flag_reg[47:32]
                    : 16'h0000;

  // Slot counter counts 0 up to the rollover value, inclusive.
  wire slot_wrap = slot_reg >= cfg_reg.slot_rollover;
  assign slot_next = slot_wrap ? 6'h00 : slot_reg + 6'h01;
  assign sync_next = slot_wrap & cfg_reg.ready_sync_gen_en;

  wire src_pending = (en_reg.power_period_irq_en & held_reg[2])
                   | (en_reg.output_check_irq_en & held_reg[1])
                   | (en_reg.overflow_irq_en & ovf_any)
                   | (en_reg.underflow_irq_en & udf_any)
                   | (en_reg.chan_limit_irq_en & held_reg[0]);
  assign irq_next = en_reg.irq_global_en
                    & (src_pending | cfg_reg.force_irq_test);
  // Clock enables for the four combiners; a set off bit stops the clock.
  // They are taken from the next config value so the output stays a flop
  // without adding a cycle of lag behind the config word.
  assign clk_en_next = ~{cfg_next.combiner_off_fourth,
                         cfg_next.combiner_off_third,
                         cfg_next.combiner_off_second,
                         cfg_next.combiner_off_first};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_reg <= modulator_config_s'(MODULATOR_CONFIG_RST);
      en_reg <= irq_enable_s'(IRQ_EN_RST);
      live_reg <= 3'h0;
      held_reg <= 3'h0;
      ovf_group_reg <= '0;
      udf_group_reg <= '0;
      fifo_flag_reg <= {FLAGS_RST, FLAGS_RST, FLAGS_RST};
      rdata_reg <= 16'h0000;
      slot_reg <= 6'h00;
      sync_reg <= 1'b0;
      irq_reg <= 1'b0;
      clk_en_reg <= 4'h0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      en_reg <= en_next;
      live_reg <= live_now;
      held_reg <= held_next;
      ovf_group_reg <= ovf_group_next;
      udf_group_reg <= udf_group_next;
      fifo_flag_reg <= fifo_flag_next;
      rdata_reg <= rdata_next;
      slot_reg <= slot_next;
      sync_reg <= sync_next;
      irq_reg <= irq_next;
      clk_en_reg <= clk_en_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign slot_count = slot_reg;
  assign ready_sync = sync_reg;
  assign single_rate_select = cfg_reg.single_rate_select;
  assign combiner_clk_en = clk_en_reg;
  assign irq = irq_reg;
endmodule

// *** rtl/mod_cfg_pkg.sv ***
// Constants and types for the modulator configuration and FIFO status block.
package mod_cfg_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam int NUM_CHAN = 128;
  localparam int GROUP_SIZE = 16;
  localparam int NUM_GROUPS = 8;
  localparam int NUM_FLAGGED = 48;

  localparam logic [10:0] MODULATOR_CONFIG_OFS = 11'h500;
  localparam logic [10:0] IRQ_ENABLE_AND_STATUS_OFS = 11'h581;
  localparam logic [10:0] FIFO_ERROR_SUMMARY_OFS = 11'h582;
  localparam logic [10:0] OVERFLOW_FLAGS_FIFO_1_16_OFS = 11'h583;
  localparam logic [10:0] OVERFLOW_FLAGS_FIFO_17_32_OFS = 11'h584;
  localparam logic [10:0] OVERFLOW_FLAGS_FIFO_33_48_OFS = 11'h585;

  localparam logic [15:0] MODULATOR_CONFIG_RST = 16'h1c4f;
  localparam logic [5:0] IRQ_EN_RST = 6'h0f;
  localparam int IRQ_EN_LSB = 10;
  localparam logic [15:0] FLAGS_RST = 16'h0000;

  // Configuration word, bit 15 down to bit 0.
  typedef struct packed {
    logic force_irq_test;
    logic spare3;
    logic [5:0] slot_rollover;
    logic spare2;
    logic ready_sync_gen_en;
    logic spare1;
    logic single_rate_select;
    logic combiner_off_fourth;
    logic combiner_off_third;
    logic combiner_off_second;
    logic combiner_off_first;
  } modulator_config_s;

  // Interrupt enables, bit 15 down to bit 10.
  typedef struct packed {
    logic irq_global_en;
    logic power_period_irq_en;
    logic output_check_irq_en;
    logic overflow_irq_en;
    logic underflow_irq_en;
    logic chan_limit_irq_en;
  } irq_enable_s;

  // Low byte of the interrupt register, bit 7 down to bit 0.
  typedef struct packed {
    logic power_period_done;
    logic output_check_active;
    logic chan_limit_hit;
    logic power_period_done_held;
    logic output_check_held;
    logic overflow_held;
    logic underflow_held;
    logic chan_limit_held;
  } irq_status_s;

  // Register port request as seen by the block.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [10:0] addr;
    logic [15:0] wdata;
  } reg_req_s;
endpackage

// *** tb/mod_cfg_irq_properties.sv ***
// Port-level properties of the configuration and interrupt block.
`timescale 1ns/10ps
module mod_cfg_irq_properties #(
  parameter int CHANNELS = 128
)(
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [10:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Events and datapath controls
  input wire logic power_period_done,
  input wire logic [CHANNELS-1:0] fifo_overflow_evt,
  input wire logic [5:0] slot_count,
  input wire logic ready_sync,
  input wire logic single_rate_select,
  input wire logic [3:0] combiner_clk_en,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic cfg_wr = reg_wr && reg_addr == 11'h500;
  wire logic en_wr = reg_wr && reg_addr == 11'h581;
  wire logic flag_rd = reg_rd && reg_addr == 11'h583;
  wire logic ev_low = fifo_overflow_evt[15:0] == 16'h0000;
  // A quiet cycle between two reads proves the first read did clear.
  sequence two_quiet_reads;
    flag_rd && ev_low ##1 ev_low ##1 flag_rd;
  endsequence
  sequence rise_then_read;
    $rose(power_period_done) ##1 reg_rd && reg_addr == 11'h581;
  endsequence
  rate_follow_a: assert property (cfg_wr |=>
    single_rate_select == $past(reg_wdata[4])) else $error("rate bit");
  comb_gate_a: assert property (cfg_wr |=>
    combiner_clk_en == ~$past(reg_wdata[3:0])) else $error("comb gate");
  slot_step_a: assert property (slot_count != 6'h00 |->
    slot_count == $past(slot_count) + 6'h01) else $error("slot step");
  sync_pulse_a: assert property (ready_sync |=> !ready_sync)
    else $error("sync width");
  irq_gate_a: assert property (en_wr && !reg_wdata[15] ##1
    (!reg_wr)[*2] |-> !irq) else $error("irq not gated");
  flag_clear_a: assert property (two_quiet_reads |=>
    reg_rdata == 16'h0000) else $error("flag not cleared");
  held_set_a: assert property (rise_then_read |=>
    reg_rdata[4]) else $error("held bit");
  group_set_a: assert property (!ev_low ##1
    reg_rd && reg_addr == 11'h582 |=> reg_rdata[0]) else $error("group");
endmodule

bind mod_cfg_irq mod_cfg_irq_properties #(.CHANNELS(CHANNELS)) u_props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .power_period_done(power_period_done),
  .fifo_overflow_evt(fifo_overflow_evt), .slot_count(slot_count),
  .ready_sync(ready_sync), .single_rate_select(single_rate_select),
  .combiner_clk_en(combiner_clk_en), .irq(irq));

// *** tb/mod_cfg_irq_tb.sv ***
// Self-checking bench for the configuration and interrupt block.
`timescale 1ns/10ps
module mod_cfg_irq_tb;
  import mod_cfg_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic ppd = 1'b0, oca = 1'b0, clh = 1'b0, sync, rate, irq;
  logic [10:0] reg_addr = 11'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [127:0] ov = 128'h0, uf = 128'h0;
  logic [5:0] slot;
  logic [3:0] clk_en;
  int num_errors = 0, samples_checked = 0;
  mod_cfg_irq u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_period_done(ppd),
    .output_check_active(oca), .chan_limit_hit(clh),
    .fifo_overflow_evt(ov), .fifo_underflow_evt(uf), .slot_count(slot),
    .ready_sync(sync), .single_rate_select(rate),
    .combiner_clk_en(clk_en), .irq(irq));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [10:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check($sformatf("reg %h", a), reg_rdata, e);
  endtask
  task automatic count_sync(input logic [15:0] e);
    logic [15:0] n;
    n = 16'h0000;
    repeat (8)
    begin
      @(posedge clk);
      #1 n = n + {15'h0000, sync};
    end
    check("sync pulses", n, e);
  endtask
  task automatic t_cfg;
    int n;
    rd(11'h500, 16'h1c4f);
    rd(11'h581, 16'h3c00);
    rd(11'h585, 16'h0000);
    wr(11'h500, 16'h0710);
    #1 check("rate", {15'h0000, rate}, 16'h0001);
    check("clk_en", {12'h000, clk_en}, 16'h000f);
    n = 0;
    while (slot !== 6'h07 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 20)
    begin
      num_errors++;
      complete_run();
    end
    @(posedge clk);
    #1 check("slot wrap", {10'h000, slot}, 16'h0000);
    wr(11'h500, 16'h0340);
    count_sync(16'h0002);
    wr(11'h500, 16'h030a);
    count_sync(16'h0000);
    check("clk_en", {12'h000, clk_en}, 16'h0005);
    $display("test config done");
  endtask
  task automatic t_irq;
    wr(11'h581, 16'hfc00);
    @(posedge clk);
    {ppd, oca, clh} <= 3'h7;
    rd(11'h581, 16'hfcf9);
    rd(11'h581, 16'hfce0);
    @(posedge clk);
    clh <= 1'b0;
    @(posedge clk);
    clh <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("irq", {15'h0000, irq}, 16'h0001);
    rd(11'h581, 16'hfce1);
    repeat (2) @(posedge clk);
    #1 check("irq", {15'h0000, irq}, 16'h0000);
    wr(11'h581, 16'h7c00);
    wr(11'h500, 16'h8310);
    repeat (2) @(posedge clk);
    #1 check("irq", {15'h0000, irq}, 16'h0000);
    wr(11'h581, 16'h8000);
    repeat (2) @(posedge clk);
    #1 check("irq", {15'h0000, irq}, 16'h0001);
    wr(11'h500, 16'h0310);
    {ppd, oca, clh} <= 3'h0;
    $display("test interrupt done");
  endtask
  task automatic t_flags;
    @(posedge clk);
    ov <= 128'h0001_8000_8000_0001;
    uf <= 128'h1 << 127;
    rd(11'h582, 16'h800f);
    @(posedge clk);
    ov <= 128'h0;
    uf <= 128'h0;
    rd(11'h583, 16'h0001);
    rd(11'h583, 16'h0000);
    rd(11'h584, 16'h8000);
    wr(11'h585, 16'hffff);
    rd(11'h585, 16'h8000);
    rd(11'h585, 16'h0000);
    $display("test flags done");
  endtask
  task automatic complete_run;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_cfg();
    t_irq();
    t_flags();
    complete_run();
  end
endmodule
